// ### design/reset_signal_generation.sv
// Central reset generator: combines power, pin, watchdog, software and
// host resets into the chip's internal resets, with an Avalon-MM slave.
// Assumes all inputs synchronous to clock; sources may assert async.
`timescale 1ns/1ps

// Overview of operation
// - Main reset from regulator and PLL rail good.
// - Some registers clear only on main or pin reset.
// - System reset from main, pin, watchdog, software, core.
// - Host link reset follows its pin only.
// - Host power reset: system reset or power-good low.
// - Power ok is inverse, gated by invert bit.
// - Host interface reset: system, power-good, invert bit.
// - Host interface reset adds selected platform reset.
// - Watchdog resets system, keeps its event count.
// - Watchdog leaves battery logic untouched.
// - Watchdog path bypasses glitch protection.
// - Watchdog reset sets sticky watchdog status bit.
// - Preserving reset only from main or pin.
// - Processor reset held 1ms after system reset.
// - Block reset needs enable bit and unlocked register.
// - Battery reset pulses on main power rise with a low cell.
module reset_signal_generation
	import reset_signal_generation_pkg::*;
#(
	parameter int BLOCKS    = 8,
	parameter int PROC_HOLD = PROC_HOLD_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              clkEn,
	input  wire logic              regulatorStable,
	input  wire logic              pllRailGood,
	input  wire logic              externalResetPin_n,
	input  wire logic              watchdogEvent,
	input  wire logic              coreResetRequest,
	input  wire logic              hostLinkResetPin_n,
	input  wire logic              hostPowerGood,
	input  wire logic              legacyBusReset_n,
	input  wire logic              platformResetWire_n,
	input  wire logic              batteryLow,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	input  wire logic [BE_W-1:0]   avs_byteenable,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   irq,
	output logic                   mainPowerDomainReset,
	output logic                   globalSystemReset,
	output logic                   watchdogPreservingReset,
	output logic                   hostLinkReset,
	output logic                   hostPowerReset,
	output logic                   hostInterfaceReset,
	output logic                   powerOkOutput,
	output logic                   processorReset,
	output logic      [BLOCKS-1:0] blockReset,
	output logic                   batteryDomainReset
);

	// Applies byte enables to a write over an old register value.
	// Lanes without an enable keep their old byte, so a narrow write to
	// one field leaves its neighbours in the same word untouched.
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wdata,
		input logic [BE_W-1:0]   be
	);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < BE_W; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = wdata[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	// Counter widths come from the counts they must hold, so the loads
	// below are cut to size on purpose and never lose a significant bit.
	localparam int GW = $clog2(GLITCH_CYCLES + 1);
	localparam int PW = $clog2(PROC_HOLD + 1);
	localparam logic [GW-1:0] GLITCH_MAX = GW'(GLITCH_CYCLES);
	localparam logic [PW-1:0] HOLD_LOAD  = PW'(PROC_HOLD - 1);

	// Raw, unsynchronised reset requests and chain outputs.
	logic [R_COUNT-1:0] rawRst;     // Async assertion terms.
	logic [R_COUNT-1:0] rstOut;     // Last stage of each chain.
	logic [BLOCKS-1:0]  blkRaw;     // Block reset requests.

	// Register state.
	ctrl_type            ctrl_q;     // Invert and select bits.
	logic [BLOCKS-1:0]   blkEn_q;    // Block reset enables.
	logic                unlocked_q; // Block enables take effect.
	logic                softPulse_q; // One-cycle software reset.
	logic [EV_W-1:0]     status_q;   // Sticky event bits.
	logic [EV_W-1:0]     irqEn_q;    // Interrupt enables.
	logic [WDCNT_W-1:0]  wdCnt_q;    // Watchdog event count.
	logic                waitReq_q;  // Bus wait state.
	logic [DATA_W-1:0]   rdData_q;   // Bus read data.
	logic                irq_q;      // Interrupt level.

	// Pin filter, stretch and edge tracking.
	logic [GW-1:0]       extCnt_q;   // Low-sample count of pin.
	logic                extFilt_q;  // Filtered pin reset.
	logic [PW-1:0]       procCnt_q;  // Processor hold counter.
	logic                procRst_q;  // Processor reset.
	logic                powerOk_q;  // Power ok pin.
	logic                pgPrev_q;   // Previous power-good.
	logic                linkPrev_q; // Previous link reset.
	logic                mainPrev_q; // Previous main reset.
	logic                batRst_q;   // Battery reset pulse.

	// Bus decode.
	// A request is accepted in the cycle in which waitrequest stands low;
	// that is the only cycle in which a write may change any register.
	wire logic accept   = (avs_read | avs_write) & ~waitReq_q;
	wire logic wrOk     = accept & avs_write;
	wire logic [ADDR_W-1:0] wordAddr = {avs_address[ADDR_W-1:2], 2'b00};
	wire logic hitCtrl  = wordAddr == OFS_CTRL;
	wire logic hitSoft  = wordAddr == OFS_SOFT;
	wire logic hitBlk   = wordAddr == OFS_BLKEN;
	wire logic hitLock  = wordAddr == OFS_LOCK;
	wire logic hitStat  = wordAddr == OFS_STATUS;
	wire logic hitClr   = wordAddr == OFS_CLEAR;
	wire logic hitIrqEn = wordAddr == OFS_IRQEN;
	wire logic hitWdCnt = wordAddr == OFS_WDCNT;
	wire logic [DATA_W-1:0] wrMerged = merge(32'h00000000, avs_writedata,
		avs_byteenable);

	// Read data; unmapped words and write-only words read as zero.
	// The mux is sampled when a read is first seen, so a register that
	// moves during the wait state still returns one coherent word.
	logic [DATA_W-1:0] rdMux;
	assign rdMux =
		hitCtrl  ? DATA_W'({ctrl_q}) :
		hitBlk   ? DATA_W'(blkEn_q) :
		hitLock  ? DATA_W'(unlocked_q) :
		hitStat  ? DATA_W'(status_q) :
		hitIrqEn ? DATA_W'(irqEn_q) :
		hitWdCnt ? DATA_W'(wdCnt_q) : 32'h00000000;

	// Event detection for the status register.
	// Power-good is watched for a fall and the link reset for a rise;
	// the watchdog bit follows the event itself, cycle by cycle.
	wire logic [EV_W-1:0] evSet = {
		rstOut[R_LINK] & ~linkPrev_q,
		pgPrev_q & ~hostPowerGood,
		watchdogEvent
	};
	wire logic [EV_W-1:0] evClr =
		(wrOk & hitClr) ? wrMerged[EV_W-1:0] : '0;

	// Platform reset chosen by the select bit.
	wire logic platRst = ctrl_q.hostResetSelect ? ~platformResetWire_n
		: ~legacyBusReset_n;

	// Source combination; these terms assert the chains at once.
	// The input reset counts as loss of main power, so it reaches every
	// chain except the link chain, including the ones that a watchdog event must not touch.
	wire logic mainRaw = sys_rst | ~(regulatorStable & pllRailGood);
	// Watchdog and core terms skip the pin filter.
	wire logic sysRaw = mainRaw | extFilt_q | watchdogEvent
		| softPulse_q | coreResetRequest;
	wire logic hpwrRaw = sysRaw | ~hostPowerGood;

	assign rawRst[R_MAIN] = mainRaw;
	assign rawRst[R_SYS]  = sysRaw;
	assign rawRst[R_WDP]  = mainRaw | extFilt_q;
	assign rawRst[R_LINK] = ~hostLinkResetPin_n;
	assign rawRst[R_HPWR] = hpwrRaw;
	// The chosen platform reset joins the host interface chain, so the
	// output keeps a single flop behind it and releases like the others.
	assign rawRst[R_HIF]  = hpwrRaw | ctrl_q.powerInvert | platRst;
	assign rawRst[R_NOK]  = hpwrRaw | ctrl_q.powerInvert;

	// Each reset sets its chain at once and releases after the stages.
	// The first stage feeds only the second, so no logic sees metastability.
	// Trade-off: a release always costs SYNC_STAGES clocks, even when the
	// source is already synchronous, in exchange for one uniform structure.
	genvar gi;
	generate
		for (gi = 0; gi < R_COUNT; gi++) begin : gSync
			logic [SYNC_STAGES-1:0] chain_q; // Shift register of ones.
			always_ff @(posedge clock or posedge rawRst[gi]) begin
				if (rawRst[gi]) begin
					chain_q <= '1;
				end else if (clkEn) begin
					chain_q <= {chain_q[SYNC_STAGES-2:0], 1'b0};
				end
			end
			assign rstOut[gi] = chain_q[SYNC_STAGES-1];
		end
		// Block resets only while enabled and unlocked.
		// Locking again releases every block through its own chain, so
		// no block leaves reset in the middle of a clock cycle.
		for (gi = 0; gi < BLOCKS; gi++) begin : gBlk
			logic [SYNC_STAGES-1:0] chain_q; // Shift register of ones.
			assign blkRaw[gi] = blkEn_q[gi] & unlocked_q;
			always_ff @(posedge clock or posedge blkRaw[gi]) begin
				if (blkRaw[gi]) begin
					chain_q <= '1;
				end else if (clkEn) begin
					chain_q <= {chain_q[SYNC_STAGES-2:0], 1'b0};
				end
			end
			assign blockReset[gi] = chain_q[SYNC_STAGES-1];
		end
	endgenerate

	// Power ok takes the value the not-ok chain's last stage will hold,
	// inverted, so it is an exact mirror yet comes from its own flop.
	// It reads the second stage only, which is already settled, so the
	// pin never sees the first stage of the synchroniser.
	always_ff @(posedge clock or posedge rawRst[R_NOK]) begin
		if (rawRst[R_NOK]) begin
			powerOk_q <= 1'b0;
		end else if (clkEn) begin
			powerOk_q <= ~gSync[R_NOK].chain_q[SYNC_STAGES-2];
		end
	end

	// Glitch filter on the reset pin: it must read low for a set number
	// of samples; a short spike on the board then causes no reset.
	// Limitation: a genuine pin reset is seen a few clocks late, and a
	// pin pulse shorter than the filter is lost entirely.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			extCnt_q  <= '0;
			extFilt_q <= 1'b0;
		end else if (clkEn) begin
			if (externalResetPin_n) begin
				extCnt_q  <= '0;
				extFilt_q <= 1'b0;
			end else if (extCnt_q != GLITCH_MAX) begin
				extCnt_q  <= extCnt_q + GW'(1);
			end else begin
				extFilt_q <= 1'b1;
			end
		end
	end

	// Processor reset stretch; sets with the system reset request and
	// counts the hold only once the system reset has released.
	// The hold is a clock count; run the block at another rate and
	// PROC_HOLD must change with it to keep the hold time.
	always_ff @(posedge clock or posedge sysRaw) begin
		if (sysRaw) begin
			procCnt_q <= HOLD_LOAD;
			procRst_q <= 1'b1;
		end else if (clkEn) begin
			if (rstOut[R_SYS]) begin
				procCnt_q <= HOLD_LOAD;
				procRst_q <= 1'b1;
			end else if (procCnt_q != '0) begin
				procCnt_q <= procCnt_q - PW'(1);
			end else begin
				procRst_q <= 1'b0;
			end
		end
	end

	// Battery reset pulse when main power rises with a low cell. It is
	// reset only by the input reset, so a watchdog never reaches it.
	// A cell that sags while main power is present changes nothing,
	// because only the release of the main reset can start a pulse.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mainPrev_q <= 1'b1;
			batRst_q   <= 1'b0;
		end else if (clkEn) begin
			mainPrev_q <= rstOut[R_MAIN];
			batRst_q   <= mainPrev_q & ~rstOut[R_MAIN] & batteryLow;
		end
	end

	// Software reset bit produces a single-cycle request; the chain
	// then stretches it, so the bit never clears itself through reset.
	// A write of zero to the bit does nothing, so software need not
	// clear it afterwards.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			softPulse_q <= 1'b0;
		end else if (clkEn) begin
			softPulse_q <= wrOk & hitSoft & wrMerged[SOFT_BIT];
		end
	end

	// Control registers live under the system reset, so a watchdog or
	// software reset returns them to defaults.
	always_ff @(posedge clock or posedge rstOut[R_SYS]) begin
		if (rstOut[R_SYS]) begin
			ctrl_q     <= CTRL_RST;
			blkEn_q    <= '0;
			unlocked_q <= 1'b0;
			irqEn_q    <= IRQEN_RST;
		end else if (clkEn && wrOk) begin
			if (hitCtrl) begin
				ctrl_q <= ctrl_type'(merge(DATA_W'({ctrl_q}), avs_writedata,
					avs_byteenable));
			end
			if (hitBlk) begin
				blkEn_q <= BLOCKS'(merge(DATA_W'(blkEn_q), avs_writedata,
					avs_byteenable));
			end
			if (hitLock) begin
				unlocked_q <= wrMerged == UNLOCK_KEY;
			end
			if (hitIrqEn) begin
				irqEn_q <= EV_W'(merge(DATA_W'(irqEn_q), avs_writedata,
					avs_byteenable));
			end
		end
	end

	// Status and watchdog count survive a watchdog reset because only
	// the preserving reset clears them. A set beats a same-cycle clear.
	// The count does not saturate; it wraps at its full width, far beyond
	// any plausible number of watchdog events between two power cycles.
	always_ff @(posedge clock or posedge rstOut[R_WDP]) begin
		if (rstOut[R_WDP]) begin
			status_q   <= '0;
			wdCnt_q    <= '0;
			pgPrev_q   <= 1'b0;
			linkPrev_q <= 1'b1;
		end else if (clkEn) begin
			status_q   <= (status_q & ~evClr) | evSet;
			pgPrev_q   <= hostPowerGood;
			linkPrev_q <= rstOut[R_LINK];
			if (watchdogEvent) begin
				wdCnt_q <= wdCnt_q + WDCNT_W'(1);
			end else if (wrOk && hitWdCnt) begin
				wdCnt_q <= '0;
			end
		end
	end

	// Bus slave: waitrequest drops for one cycle after a request is seen,
	// and that is the cycle in which a write lands and read data stands.
	// Each transfer costs two cycles; the bus is simple rather than fast,
	// which suits a block that software touches only a few times.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			waitReq_q <= 1'b1;
			rdData_q  <= '0;
			irq_q     <= 1'b0;
		end else if (clkEn) begin
			waitReq_q <= ~((avs_read | avs_write) & waitReq_q);
			if (avs_read && waitReq_q) begin
				rdData_q <= rdMux;
			end
			irq_q <= |(status_q & irqEn_q);
		end
	end

	// Outputs straight from flops.
	assign mainPowerDomainReset    = rstOut[R_MAIN];
	assign globalSystemReset       = rstOut[R_SYS];
	assign watchdogPreservingReset = rstOut[R_WDP];
	assign hostLinkReset           = rstOut[R_LINK];
	assign hostPowerReset          = rstOut[R_HPWR];
	assign hostInterfaceReset      = rstOut[R_HIF];
	assign powerOkOutput           = powerOk_q;
	assign processorReset          = procRst_q;
	assign batteryDomainReset      = batRst_q;
	assign avs_readdata            = rdData_q;
	assign avs_waitrequest         = waitReq_q;
	assign irq                     = irq_q;

	// Limitations for whoever integrates this block:
	// every derived reset asserts through combinational glue, so a glitch
	// on a source input reaches the outputs; only the reset pin is filtered.
	// Watchdog, core and software requests are not filtered, on purpose,
	// so that a one-cycle watchdog pulse still resets the system.
	// While clkEn is low no reset can release, yet every reset but the battery pulse and the block resets can still
	// assert, so a frozen clock never masks a power failure.

endmodule : reset_signal_generation

// ### design/reset_signal_generation_pkg.sv
// Constants, register map and carrier types of the reset generator.
// Assumes one 20 MHz clock and an Avalon-MM host with 32-bit data.
package reset_signal_generation_pkg;
	// Bus geometry; byte addresses, one aligned word per register.
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_SOFT   = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_BLKEN  = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_LOCK   = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_CLEAR  = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQEN  = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_WDCNT  = 5'h1c;
	// Field positions.
	localparam int CTRL_INV_BIT = 0;
	localparam int CTRL_SEL_BIT = 1;
	localparam int SOFT_BIT     = 0;
	localparam int LOCK_BIT     = 0;
	// Event and status bits.
	localparam int EV_WDT   = 0;
	localparam int EV_PGOOD = 1;
	localparam int EV_LINK  = 2;
	localparam int EV_W     = 3;
	// Reset values.
	localparam logic [EV_W-1:0] IRQEN_RST = 3'h0;
	localparam int WDCNT_W = 16;
	// Unlock key of the block reset enables; the value is arbitrary.
	localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h0000a5a5;
	// Timing.
	localparam int CLOCK_HZ        = 20000000;
	localparam int CLOCK_PERIOD_NS = 50;
	localparam int SYNC_STAGES     = 3;
	localparam int PROC_HOLD_MS     = 1;
	localparam int PROC_HOLD_CYCLES = (CLOCK_HZ / 1000) * PROC_HOLD_MS;
	localparam int GLITCH_NS     = 200;
	localparam int GLITCH_CYCLES =
		(GLITCH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// Indices of the synchronised reset chains.
	localparam int R_MAIN  = 0;
	localparam int R_SYS   = 1;
	localparam int R_WDP   = 2;
	localparam int R_LINK  = 3;
	localparam int R_HPWR  = 4;
	localparam int R_HIF   = 5;
	localparam int R_NOK   = 6;
	localparam int R_COUNT = 7;
	// Control register carrier.
	typedef struct packed {
		logic hostResetSelect;
		logic powerInvert;
	} ctrl_type;
	localparam ctrl_type CTRL_RST = '{hostResetSelect: 1'b0, powerInvert: 1'b0};
endpackage : reset_signal_generation_pkg

// ### verification/reset_signal_generation_props.sv
// Concurrent checks on the reset generator's top-level ports.
// Assumes one clock domain and that sys_rst disables every check.
`timescale 1ns/1ps
module reset_signal_generation_props
	import reset_signal_generation_pkg::*;
#(
	parameter int BLOCKS    = 8,
	parameter int PROC_HOLD = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic regulatorStable,
	input wire logic pllRailGood,
	input wire logic externalResetPin_n,
	input wire logic watchdogEvent,
	input wire logic hostLinkResetPin_n,
	input wire logic hostPowerGood,
	input wire logic mainPowerDomainReset,
	input wire logic globalSystemReset,
	input wire logic watchdogPreservingReset,
	input wire logic hostLinkReset,
	input wire logic hostPowerReset,
	input wire logic hostInterfaceReset,
	input wire logic powerOkOutput,
	input wire logic processorReset,
	input wire logic batteryDomainReset
);
	// Resets assert combinationally, so causes are checked in the same cycle.
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_main_source: assert property (!regulatorStable || !pllRailGood |-> mainPowerDomainReset)
		else $error("main reset missing while a rail is down");
	a_wdt_system: assert property (watchdogEvent |-> globalSystemReset)
		else $error("watchdog event did not raise system reset");
	a_link_pin: assert property (!hostLinkResetPin_n |-> hostLinkReset)
		else $error("link reset missing while its pin is low");
	a_link_release: assert property ($rose(hostLinkResetPin_n) |->
		hostLinkReset ##1 hostLinkReset ##[1:3] !hostLinkReset)
		else $error("link reset release not synchronised");
	a_hpwr_source: assert property (globalSystemReset || !hostPowerGood |-> hostPowerReset)
		else $error("host power reset missing");
	a_pok_inverse: assert property (hostPowerReset |-> !powerOkOutput)
		else $error("power ok high during host power reset");
	a_hif_source: assert property (globalSystemReset || !hostPowerGood |-> hostInterfaceReset)
		else $error("host interface reset missing");
	a_wdp_cause: assert property ($rose(watchdogPreservingReset) |->
		mainPowerDomainReset || !externalResetPin_n)
		else $error("preserving reset rose without main or pin");
	a_proc_with: assert property (globalSystemReset |-> processorReset)
		else $error("processor reset low during system reset");
	a_proc_hold: assert property ($fell(globalSystemReset) |-> processorReset [*4])
		else $error("processor reset not stretched");
	a_bat_pulse: assert property (batteryDomainReset |=> !batteryDomainReset)
		else $error("battery reset longer than one cycle");
endmodule : reset_signal_generation_props

bind reset_signal_generation reset_signal_generation_props #(
	.BLOCKS(BLOCKS), .PROC_HOLD(PROC_HOLD)) props_u (
	.clock(clock), .sys_rst(sys_rst), .regulatorStable(regulatorStable),
	.pllRailGood(pllRailGood), .externalResetPin_n(externalResetPin_n),
	.watchdogEvent(watchdogEvent), .hostLinkResetPin_n(hostLinkResetPin_n),
	.hostPowerGood(hostPowerGood), .mainPowerDomainReset(mainPowerDomainReset),
	.globalSystemReset(globalSystemReset), .watchdogPreservingReset(watchdogPreservingReset),
	.hostLinkReset(hostLinkReset), .hostPowerReset(hostPowerReset),
	.hostInterfaceReset(hostInterfaceReset), .powerOkOutput(powerOkOutput),
	.processorReset(processorReset), .batteryDomainReset(batteryDomainReset));

// ### verification/power_rail_model.sv
// Board model: rails, reset pins and host platform resets.
// Assumes the bench states the wanted level of every line.
`timescale 1ns/1ps
module power_rail_model (
	input  wire logic       clock,
	input  wire logic [9:0] want,
	output logic      [9:0] pins
);
	// Lines move only at a clock edge, like a slow board supervisor.
	initial pins = 10'h39e;
	always @(posedge clock) pins <= want;
endmodule : power_rail_model

// ### verification/testbench.sv
// Self-checking bench of the reset generator with a board model.
// Assumes a short processor hold count so the run stays brief.
`timescale 1ns/1ps
module testbench;
	import reset_signal_generation_pkg::*;
	localparam int HOLD = 8;
	logic clock, sys_rst, rd, wr, wreq, irq, mpr, gsr, wdp, hlr, hpr, hif, pok, prc, bat;
	logic [9:0] want, p;
	logic [ADDR_W-1:0] adr;
	logic [DATA_W-1:0] wdat, rdat, rq;
	logic [7:0] blk;
	logic ce; // Clock enable of the block.
	int num_errors, total_checks, batPulses;
	// Line order of the board: reg, pll, pin, wdt, core, link, pgood, legacy, wire, battery.
	power_rail_model board_u (.clock(clock), .want(want), .pins(p));
	reset_signal_generation #(.BLOCKS(8), .PROC_HOLD(HOLD)) dut_u (
		.clock(clock), .sys_rst(sys_rst), .clkEn(ce), .regulatorStable(p[9]),
		.pllRailGood(p[8]), .externalResetPin_n(p[7]), .watchdogEvent(p[6]),
		.coreResetRequest(p[5]), .hostLinkResetPin_n(p[4]), .hostPowerGood(p[3]),
		.legacyBusReset_n(p[2]), .platformResetWire_n(p[1]), .batteryLow(p[0]),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
		.avs_byteenable(4'hf), .avs_readdata(rq), .avs_waitrequest(wreq), .irq(irq),
		.mainPowerDomainReset(mpr), .globalSystemReset(gsr), .watchdogPreservingReset(wdp),
		.hostLinkReset(hlr), .hostPowerReset(hpr), .hostInterfaceReset(hif),
		.powerOkOutput(pok), .processorReset(prc), .blockReset(blk), .batteryDomainReset(bat));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Counts battery reset pulses, so a missed or an extra one shows up.
	always @(posedge clock) if (bat === 1'b1) batPulses++;
	// Prints the counts and the verdict, then ends the run.
	task test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	// One Avalon transfer, held until waitrequest is sampled low.
	task bus(input logic isW, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		int k;
		@(posedge clock);
		adr <= a;
		wdat <= v;
		rd <= !isW;
		wr <= isW;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		if (k >= 50) begin
			num_errors++;
			test_done();
		end
		rdat = rq;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	// Waits for the system reset to end, then waits out the processor reset hold.
	task settle;
		int k;
		k = 0;
		while (gsr !== 1'b0 && k < 200) begin
			@(posedge clock);
			k++;
		end
		if (k >= 200) begin
			num_errors++;
			test_done();
		end
		cyc(HOLD + 4);
	endtask : settle
	task t_boot;
		int k;
		k = 0;
		while (gsr !== 1'b0 && k < 50) begin
			chk(prc, 1'b1);
			@(posedge clock);
			k++;
		end
		k = 0;
		while (prc === 1'b1 && k < 50) begin
			@(posedge clock);
			k++;
		end
		chk(k, HOLD);
		cyc(4);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk(rdat, 32'h0);
		bus(1'b0, OFS_IRQEN, 32'h0);
		chk(rdat, {29'h0, IRQEN_RST});
	endtask : t_boot
	task t_wdt;
		want[6] <= 1'b1;
		want[0] <= 1'b1;
		cyc(1);
		want[6] <= 1'b0;
		cyc(1);
		chk(gsr, 1'b1);
		chk(wdp, 1'b0);
		settle();
		chk(batPulses, 0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rdat[EV_WDT], 1'b1);
		bus(1'b0, OFS_WDCNT, 32'h0);
		chk(rdat, 32'h1);
		bus(1'b1, OFS_IRQEN, 32'h1);
		cyc(2);
		chk(irq, 1'b1);
		bus(1'b1, OFS_IRQEN, 32'h0);
		cyc(2);
		chk(irq, 1'b0);
		bus(1'b1, OFS_CLEAR, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rdat[EV_WDT], 1'b0);
		want[0] <= 1'b0;
	endtask : t_wdt
	task t_pin;
		want[7] <= 1'b0;
		cyc(2);
		want[7] <= 1'b1;
		cyc(4);
		chk(gsr, 1'b0);
		want[7] <= 1'b0;
		cyc(8);
		chk(gsr, 1'b1);
		chk(wdp, 1'b1);
		want[7] <= 1'b1;
		settle();
		bus(1'b0, OFS_WDCNT, 32'h0);
		chk(rdat, 32'h0);
	endtask : t_pin
	task t_host;
		want[3] <= 1'b0;
		want[4] <= 1'b0;
		cyc(2);
		chk({hpr, hif, pok, gsr, hlr}, 5'b11001);
		want[3] <= 1'b1;
		want[4] <= 1'b1;
		cyc(6);
		chk({hpr, hif, pok, hlr}, 4'b0010);
		bus(1'b1, OFS_CLEAR, 32'h2);
		bus(1'b1, OFS_CTRL, 32'h1);
		cyc(2);
		chk({hpr, hif, pok}, 3'b010);
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, OFS_CTRL, s << CTRL_SEL_BIT);
			cyc(5);
			want[2] <= 1'b0;
			cyc(2);
			chk(hif, s == 0);
			want[2] <= 1'b1;
			cyc(5);
			want[1] <= 1'b0;
			cyc(2);
			chk(hif, s == 1);
			want[1] <= 1'b1;
			cyc(5);
		end
	endtask : t_host
	task t_sys;
		want[5] <= 1'b1;
		cyc(2);
		chk({gsr, wdp}, 2'b10);
		want[5] <= 1'b0;
		settle();
		bus(1'b1, OFS_SOFT, 32'h1);
		cyc(1);
		chk({gsr, wdp}, 2'b10);
		settle();
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rdat[EV_LINK], 1'b1);
	endtask : t_sys
	task t_block;
		bus(1'b1, OFS_BLKEN, 32'h5);
		cyc(2);
		chk(blk, 8'h0);
		bus(1'b1, OFS_LOCK, UNLOCK_KEY);
		bus(1'b0, OFS_LOCK, 32'h0);
		chk(rdat, 32'h1);
		chk(blk, 8'h5);
		bus(1'b1, OFS_LOCK, 32'h0);
		ce <= 1'b0;
		cyc(6);
		chk(blk, 8'h5);
		ce <= 1'b1;
		cyc(4);
		chk(blk, 8'h0);
	endtask : t_block
	task t_power;
		int k;
		want[0] <= 1'b1;
		want[9] <= 1'b0;
		cyc(2);
		chk({mpr, gsr, wdp}, 3'b111);
		want[9] <= 1'b1;
		k = 0;
		while (bat !== 1'b1 && k < 20) begin
			@(posedge clock);
			k++;
		end
		chk(k < 20, 1'b1);
		cyc(1);
		chk(bat, 1'b0);
		want[0] <= 1'b0;
		want[8] <= 1'b0;
		cyc(2);
		chk(mpr, 1'b1);
		want[8] <= 1'b1;
		settle();
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rdat, 32'h0);
		chk(batPulses, 1);
	endtask : t_power
	initial begin
		num_errors = 0;
		total_checks = 0;
		batPulses = 0;
		ce = 1'b1;
		sys_rst = 1'b1;
		want = 10'h39e;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wdat = 32'h0;
		cyc(10);
		sys_rst <= 1'b0;
		cyc(1);
		t_boot();
		t_wdt();
		t_pin();
		t_host();
		t_sys();
		t_block();
		t_power();
		test_done();
	end
endmodule : testbench
